/* File: rce_defs.vh */
// Purpose: constants of the 8-bit risc execution core
// Assumes: one clock mclk, asynchronous active-low reset rstn
// Notes: instruction encoding below is this core's own
// Function
// - thirty-two byte registers, each read or written in one cycle
// - two operands read, alu run and result written back in one cycle
// - r31:r30 form a 16-bit pointer into registers, i/o and program memory
// - alu works on two registers, register and constant, or one register
// - next word is prefetched while current one executes, one per cycle
// - every instruction is one 16-bit word, one per program address
// - relative jump and call reach every program address
// - calls and interrupt entry save return pc on a three-deep stack
// - sixty-four i/o addresses are decoded, 3f for the status register and the rest for peripheral registers
// - global interrupt enable bit lives in the status register
// - each source has its own vector at the start of program memory
// - of several pending sources the lowest vector address wins
// - idle halts execution while interrupts and peripherals keep running
// - power-down keeps registers, stops oscillators until interrupt or reset
// - push shifts entries deeper, pop takes top and shifts others up
// - beyond three nested calls oldest is lost, deepest entry repeats
// - program counter and stack entries are nine bits, 512 words
`ifndef RCE_DEFS_VH
`define RCE_DEFS_VH
`define RCE_PC_W      9
`define RCE_STK_DEPTH 3
`define RCE_NREGS     32
`define RCE_IRQ_N     8
`define RCE_PC_RST    9'h000
`define RCE_VEC_FIRST 9'h001
`define RCE_PC_ONE    9'h001
// major opcodes, bits 15:12; reg-reg when bits 15:14 are zero
`define RCE_OP_RR    2'b00
`define RCE_OP_SUBI  4'h4
`define RCE_OP_ANDI  4'h5
`define RCE_OP_ORI   4'h6
`define RCE_OP_LDI   4'h7
`define RCE_OP_CPI   4'h8
`define RCE_OP_MISC  4'h9
`define RCE_OP_BRB   4'ha
`define RCE_OP_IO    4'hb
`define RCE_OP_RJMP  4'hc
`define RCE_OP_RCALL 4'hd
// misc sub-opcodes, bits 11:8; 0..5 are single-register alu ops
`define RCE_MS_LDZ   4'h6
`define RCE_MS_STZ   4'h7
`define RCE_MS_LPM   4'h8
`define RCE_MS_RET   4'h9
`define RCE_MS_RETI  4'ha
`define RCE_MS_SEI   4'hb
`define RCE_MS_CLI   4'hc
`define RCE_MS_SLEEP 4'hd
// alu codes
`define RCE_ALU_ADD 4'h0
`define RCE_ALU_ADC 4'h1
`define RCE_ALU_SUB 4'h2
`define RCE_ALU_SBC 4'h3
`define RCE_ALU_AND 4'h4
`define RCE_ALU_OR  4'h5
`define RCE_ALU_EOR 4'h6
`define RCE_ALU_MOV 4'h7
`define RCE_ALU_CP  4'h8
`define RCE_ALU_CPC 4'h9
`define RCE_ALU_COM 4'ha
`define RCE_ALU_NEG 4'hb
`define RCE_ALU_INC 4'hc
`define RCE_ALU_DEC 4'hd
`define RCE_ALU_LSR 4'he
`define RCE_ALU_ROR 4'hf
// status register bits and reset
`define RCE_SR_C 0
`define RCE_SR_Z 1
`define RCE_SR_N 2
`define RCE_SR_V 3
`define RCE_SR_S 4
`define RCE_SR_I 7
`define RCE_SR_RST 8'h00
// address map of the pointer
`define RCE_SREG_IO  6'h3f
`define RCE_IO_BASE  6'h20
`define RCE_Z_RF_END 16'h0020
`define RCE_Z_IO_END 16'h0060
// core states, one-hot
`define RCE_ST_RUN 3'b001
`define RCE_ST_PH2 3'b010
`define RCE_ST_SLP 3'b100
`endif

/* File: rce_regfile.v */
// Purpose: 32 x 8 working registers, two registered read ports
// Assumes: read addresses come one cycle ahead of use
// Notes: a write at the same edge is forwarded to the read data
`timescale 1ns/1ps
`include "rce_defs.vh"
module rce_regfile (
  input  wire       mclk,
  input  wire       rstn,
  input  wire [4:0] ra_addr,
  input  wire [4:0] rb_addr,
  input  wire       we,
  input  wire [4:0] wa,
  input  wire [7:0] wd,
  output reg  [7:0] ra_q,
  output reg  [7:0] rb_q,
  output wire [15:0] z_ptr
);
  reg [7:0] mem_r [0:`RCE_NREGS-1];
  integer i;
  assign z_ptr = {mem_r[31], mem_r[30]};
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < `RCE_NREGS; i = i + 1)
        mem_r[i] <= 8'h00;
      ra_q <= 8'h00;
      rb_q <= 8'h00;
    end else begin
      if (we)
        mem_r[wa] <= wd;
      ra_q <= (we && wa == ra_addr) ? wd : mem_r[ra_addr];
      rb_q <= (we && wa == rb_addr) ? wd : mem_r[rb_addr];
    end
  end
endmodule

/* File: rce_hwstack.v */
// Purpose: three-level return address stack
// Assumes: push and pop never in the same cycle
// Notes: overflow drops the oldest entry, underflow repeats the deepest
`timescale 1ns/1ps
`include "rce_defs.vh"
module rce_hwstack (
  input  wire                 mclk,
  input  wire                 rstn,
  input  wire                 push,
  input  wire                 pop,
  input  wire [`RCE_PC_W-1:0] din,
  output wire [`RCE_PC_W-1:0] top
);
  reg [`RCE_PC_W-1:0] lvl_r [0:`RCE_STK_DEPTH-1];
  integer i;
  assign top = lvl_r[0];
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < `RCE_STK_DEPTH; i = i + 1)
        lvl_r[i] <= `RCE_PC_RST;
    end else if (push) begin
      lvl_r[0] <= din;
      for (i = 1; i < `RCE_STK_DEPTH; i = i + 1)
        lvl_r[i] <= lvl_r[i-1];
    end else if (pop) begin
      for (i = 0; i < `RCE_STK_DEPTH - 1; i = i + 1)
        lvl_r[i] <= lvl_r[i+1];
    end
  end
endmodule

/* File: rce_core.v */
// Purpose: fetch/execute core with alu, i/o decode, interrupts and sleep
// Assumes: program memory answers pm_addr combinationally in the same cycle
// Notes: irq_req comes already masked by the peripherals' own enables
`timescale 1ns/1ps
`include "rce_defs.vh"
module rce_core (
  input  wire                  mclk,
  input  wire                  rstn,
  output wire [`RCE_PC_W-1:0]  pm_addr,
  input  wire [15:0]           pm_data,
  output reg  [5:0]            io_addr,
  output wire [7:0]            io_wdata,
  output reg                   io_wr,
  output reg                   io_rd,
  input  wire [7:0]            io_rdata,
  input  wire [`RCE_IRQ_N-1:0] irq_req,
  output wire [`RCE_IRQ_N-1:0] irq_ack,
  input  wire                  sleep_pd,
  output wire                  cpu_idle,
  output reg                   osc_stop,
  output wire                  gie
);
  reg [`RCE_PC_W-1:0] pc_r, ir_pc_r, pc_nxt;
  reg [15:0] ir_r;
  reg        valid_r, valid_nxt;
  reg [2:0]  st_r, st_nxt;
  reg [7:0]  sreg_r, sreg_nxt;
  reg [5:0]  ioa_nxt;
  reg        osc_nxt;
  reg        rf_we, push, pop, hold, flush, lpm_rd, two_ph;
  reg [7:0]  rf_wd;
  reg [3:0]  alu_op;
  reg [7:0]  alu_b, res;
  reg [8:0]  sum;
  reg [4:0]  fl;
  reg        cin, setf, wr_res;
  reg [2:0]  irq_idx;
  reg        irq_hit;
  wire [7:0]  ra_q, rb_q;
  wire [15:0] z_ptr;
  wire [`RCE_PC_W-1:0] stk_top;
  wire [3:0] op = ir_r[15:12];
  wire [3:0] ms = ir_r[11:8];
  wire is_rr = ir_r[15:14] == `RCE_OP_RR;
  wire is_imm = op >= `RCE_OP_SUBI && op <= `RCE_OP_CPI;
  wire ex_valid = valid_r && st_r == `RCE_ST_RUN;
  wire irq_take = ex_valid && sreg_r[`RCE_SR_I] && irq_hit;
  wire z_rf = z_ptr < `RCE_Z_RF_END;
  wire z_io = !z_rf && z_ptr < `RCE_Z_IO_END;
  wire ph2 = st_r == `RCE_ST_PH2;
  wire is_sreg = io_addr == `RCE_SREG_IO;
  wire [7:0] io_val = is_sreg ? sreg_r : io_rdata;
  wire [7:0] lpm_byte = z_ptr[0] ? pm_data[15:8] : pm_data[7:0];
  wire [`RCE_PC_W-1:0] rel12 = ir_pc_r + ir_r[8:0] + `RCE_PC_ONE;
  wire [`RCE_PC_W-1:0] rel8 = ir_pc_r + {ir_r[7], ir_r[7:0]} + `RCE_PC_ONE;
  wire [4:0] ra_addr, rb_addr, rf_wa;
  integer i;

  // destination field per instruction format
  function [4:0] fld_d;
    input [15:0] w;
    begin
      if (w[15:14] == `RCE_OP_RR)
        fld_d = w[9:5];
      else if (w[15:12] >= `RCE_OP_SUBI && w[15:12] <= `RCE_OP_CPI)
        fld_d = {1'b1, w[11:8]};
      else
        fld_d = w[4:0];
    end
  endfunction

  assign ra_addr = (ex_valid && op == `RCE_OP_MISC && ms == `RCE_MS_LDZ && !irq_take) ? z_ptr[4:0] :
                   hold ? fld_d(ir_r) : fld_d(pm_data);
  assign rb_addr = hold ? ir_r[4:0] : pm_data[4:0];
  assign rf_wa = (ph2 && ms == `RCE_MS_STZ) ? z_ptr[4:0] : fld_d(ir_r);
  assign pm_addr = lpm_rd ? z_ptr[9:1] : pc_r;
  assign io_wdata = rb_q;
  assign gie = sreg_r[`RCE_SR_I];
  assign cpu_idle = st_r == `RCE_ST_SLP;
  assign irq_ack = irq_take ? ({{(`RCE_IRQ_N-1){1'b0}}, 1'b1} << irq_idx) : {`RCE_IRQ_N{1'b0}};

  rce_regfile u_rf (
    .mclk    (mclk),
    .rstn    (rstn),
    .ra_addr (ra_addr),
    .rb_addr (rb_addr),
    .we      (rf_we),
    .wa      (rf_wa),
    .wd      (rf_wd),
    .ra_q    (ra_q),
    .rb_q    (rb_q),
    .z_ptr   (z_ptr)
  );

  rce_hwstack u_stk (
    .mclk (mclk),
    .rstn (rstn),
    .push (push),
    .pop  (pop),
    .din  (irq_take ? ir_pc_r : ir_pc_r + `RCE_PC_ONE),
    .top  (stk_top)
  );

  // lowest pending index has the lowest vector address
  always @* begin
    irq_idx = 3'h0;
    irq_hit = 1'b0;
    for (i = `RCE_IRQ_N - 1; i >= 0; i = i - 1)
      if (irq_req[i]) begin
        irq_idx = i[2:0];
        irq_hit = 1'b1;
      end
  end

  // operand and operation select
  always @* begin
    alu_b = is_rr ? rb_q : ir_r[7:0];
    case (op)
      `RCE_OP_SUBI: alu_op = `RCE_ALU_SUB;
      `RCE_OP_ANDI: alu_op = `RCE_ALU_AND;
      `RCE_OP_ORI:  alu_op = `RCE_ALU_OR;
      `RCE_OP_LDI:  alu_op = `RCE_ALU_MOV;
      `RCE_OP_CPI:  alu_op = `RCE_ALU_CP;
      `RCE_OP_MISC: alu_op = ms + `RCE_ALU_COM;
      default:      alu_op = is_rr ? ir_r[13:10] : `RCE_ALU_MOV;
    endcase
  end

  // alu: result and new c z n v s
  always @* begin
    cin = sreg_r[`RCE_SR_C] && (alu_op == `RCE_ALU_ADC || alu_op == `RCE_ALU_SBC || alu_op == `RCE_ALU_CPC);
    sum = 9'h000;
    res = ra_q;
    fl = sreg_r[4:0];
    setf = 1'b1;
    wr_res = 1'b1;
    case (alu_op)
      `RCE_ALU_ADD, `RCE_ALU_ADC: begin
        sum = {1'b0, ra_q} + {1'b0, alu_b} + {8'h00, cin};
        res = sum[7:0];
        fl[`RCE_SR_C] = sum[8];
        fl[`RCE_SR_V] = (ra_q[7] & alu_b[7] & ~res[7]) | (~ra_q[7] & ~alu_b[7] & res[7]);
      end
      `RCE_ALU_SUB, `RCE_ALU_SBC, `RCE_ALU_CP, `RCE_ALU_CPC: begin
        sum = {1'b0, ra_q} - {1'b0, alu_b} - {8'h00, cin};
        res = sum[7:0];
        fl[`RCE_SR_C] = sum[8];
        fl[`RCE_SR_V] = (ra_q[7] & ~alu_b[7] & ~res[7]) | (~ra_q[7] & alu_b[7] & res[7]);
        wr_res = alu_op == `RCE_ALU_SUB || alu_op == `RCE_ALU_SBC;
      end
      `RCE_ALU_AND: res = ra_q & alu_b;
      `RCE_ALU_OR:  res = ra_q | alu_b;
      `RCE_ALU_EOR: res = ra_q ^ alu_b;
      `RCE_ALU_COM: begin
        res = ~ra_q;
        fl[`RCE_SR_C] = 1'b1;
      end
      `RCE_ALU_NEG: begin
        res = 8'h00 - ra_q;
        fl[`RCE_SR_C] = res != 8'h00;
        fl[`RCE_SR_V] = res == 8'h80;
      end
      `RCE_ALU_INC: begin
        res = ra_q + 8'h01;
        fl[`RCE_SR_V] = res == 8'h80;
      end
      `RCE_ALU_DEC: begin
        res = ra_q - 8'h01;
        fl[`RCE_SR_V] = res == 8'h7f;
      end
      `RCE_ALU_LSR, `RCE_ALU_ROR: begin
        res = {alu_op == `RCE_ALU_ROR && sreg_r[`RCE_SR_C], ra_q[7:1]};
        fl[`RCE_SR_C] = ra_q[0];
        fl[`RCE_SR_V] = res[7] ^ ra_q[0];
      end
      default: begin
        res = alu_b;
        setf = 1'b0;
      end
    endcase
    if (alu_op == `RCE_ALU_AND || alu_op == `RCE_ALU_OR || alu_op == `RCE_ALU_EOR || alu_op == `RCE_ALU_COM)
      fl[`RCE_SR_V] = 1'b0;
    fl[`RCE_SR_Z] = (res == 8'h00) && (!cin_chain(alu_op) || sreg_r[`RCE_SR_Z]);
    fl[`RCE_SR_N] = res[7];
    fl[`RCE_SR_S] = res[7] ^ fl[`RCE_SR_V];
  end

  function cin_chain;
    input [3:0] a;
    begin
      cin_chain = a == `RCE_ALU_SBC || a == `RCE_ALU_CPC;
    end
  endfunction

  // execute stage and next-state decisions
  always @* begin
    pc_nxt = pc_r + `RCE_PC_ONE;
    valid_nxt = 1'b1;
    st_nxt = st_r;
    sreg_nxt = sreg_r;
    ioa_nxt = pm_data[10:5];
    osc_nxt = 1'b0;
    rf_we = 1'b0;
    rf_wd = res;
    push = 1'b0;
    pop = 1'b0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    lpm_rd = 1'b0;
    flush = 1'b0;
    two_ph = ex_valid && op == `RCE_OP_MISC && ms >= `RCE_MS_LDZ && ms <= `RCE_MS_LPM;
    hold = (st_r == `RCE_ST_SLP) || (two_ph && !irq_take);
    case (st_r)
      `RCE_ST_RUN: begin
        if (irq_take) begin
          push = 1'b1;
          pc_nxt = `RCE_VEC_FIRST + {6'h00, irq_idx};
          sreg_nxt[`RCE_SR_I] = 1'b0;
          flush = 1'b1;
        end else if (ex_valid) begin
          if (is_rr || is_imm || (op == `RCE_OP_MISC && ms < `RCE_MS_LDZ)) begin
            rf_we = wr_res;
            if (setf)
              sreg_nxt[4:0] = fl;
          end else if (two_ph) begin
            st_nxt = `RCE_ST_PH2;
            ioa_nxt = z_ptr[5:0] - `RCE_IO_BASE;
          end else if (op == `RCE_OP_MISC) begin
            case (ms)
              `RCE_MS_RET, `RCE_MS_RETI: begin
                pop = 1'b1;
                pc_nxt = stk_top;
                flush = 1'b1;
                if (ms == `RCE_MS_RETI)
                  sreg_nxt[`RCE_SR_I] = 1'b1;
              end
              `RCE_MS_SEI: sreg_nxt[`RCE_SR_I] = 1'b1;
              `RCE_MS_CLI: sreg_nxt[`RCE_SR_I] = 1'b0;
              `RCE_MS_SLEEP: begin
                st_nxt = `RCE_ST_SLP;
                osc_nxt = sleep_pd;
              end
              default: ;
            endcase
          end else if (op == `RCE_OP_BRB) begin
            if (sreg_r[ir_r[10:8]] == ir_r[11]) begin
              pc_nxt = rel8;
              flush = 1'b1;
            end
          end else if (op == `RCE_OP_IO) begin
            if (ir_r[11]) begin
              io_wr = !is_sreg;
              if (is_sreg)
                sreg_nxt = rb_q;
            end else begin
              io_rd = !is_sreg;
              rf_we = 1'b1;
              rf_wd = io_val;
            end
          end else if (op == `RCE_OP_RJMP || op == `RCE_OP_RCALL) begin
            push = op == `RCE_OP_RCALL;
            pc_nxt = rel12;
            flush = 1'b1;
          end
        end
      end
      `RCE_ST_PH2: begin
        st_nxt = `RCE_ST_RUN;
        case (ms)
          `RCE_MS_LDZ: begin
            io_rd = z_io && !is_sreg;
            rf_we = 1'b1;
            rf_wd = z_rf ? ra_q : (z_io ? io_val : 8'h00);
          end
          `RCE_MS_STZ: begin
            io_wr = z_io && !is_sreg;
            rf_we = z_rf;
            rf_wd = rb_q;
            if (z_io && is_sreg)
              sreg_nxt = rb_q;
          end
          default: begin
            lpm_rd = 1'b1;
            rf_we = 1'b1;
            rf_wd = lpm_byte;
            pc_nxt = pc_r;
            flush = 1'b1;
          end
        endcase
      end
      `RCE_ST_SLP: begin
        osc_nxt = osc_stop;
        if (irq_hit) begin
          st_nxt = `RCE_ST_RUN;
          osc_nxt = 1'b0;
        end
      end
      default: st_nxt = `RCE_ST_RUN;
    endcase
    if (hold) begin
      pc_nxt = pc_r;
      ioa_nxt = (two_ph && !irq_take) ? ioa_nxt : io_addr;
    end
    if (flush)
      valid_nxt = 1'b0;
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= `RCE_PC_RST;
      ir_pc_r <= `RCE_PC_RST;
      ir_r <= 16'h0000;
      valid_r <= 1'b0;
      st_r <= `RCE_ST_RUN;
      sreg_r <= `RCE_SR_RST;
      io_addr <= 6'h00;
      osc_stop <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      st_r <= st_nxt;
      sreg_r <= sreg_nxt;
      io_addr <= ioa_nxt;
      osc_stop <= osc_nxt;
      if (!hold) begin
        ir_r <= pm_data;
        ir_pc_r <= pc_r;
        valid_r <= valid_nxt;
      end
    end
  end
endmodule

/* File: rce_stz_note_unused.v */
`timescale 1ns/1ps

/* File: rce_core_props.sv */
// Purpose: concurrent checks on the ports of the execution core
// Assumes: one clock mclk, asynchronous active-low reset rstn
// Notes: bound into every rce_core instance
`timescale 1ns/1ps
`include "rce_defs.vh"
module rce_core_chk (
  input wire                  mclk,
  input wire                  rstn,
  input wire [`RCE_PC_W-1:0]  pm_addr,
  input wire [5:0]            io_addr,
  input wire                  io_wr,
  input wire                  io_rd,
  input wire [`RCE_IRQ_N-1:0] irq_req,
  input wire [`RCE_IRQ_N-1:0] irq_ack,
  input wire                  cpu_idle,
  input wire                  osc_stop,
  input wire                  gie
);
  reg [`RCE_PC_W-1:0] ack_vec;
  integer             i;
  // vector address of the acknowledged source
  always @* begin
    ack_vec = `RCE_PC_RST;
    for (i = 0; i < `RCE_IRQ_N; i = i + 1) begin
      if (irq_ack[i]) ack_vec = `RCE_VEC_FIRST + i[8:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_ack_one_hot: assert property (irq_ack != 8'h00 |-> $onehot(irq_ack))
    else $error("irq_ack not one-hot");
  chk_ack_needs_gie: assert property (irq_ack != 8'h00 |-> gie)
    else $error("interrupt taken with gie clear");
  chk_ack_lowest_vector: assert property (irq_ack != 8'h00 |->
    ((irq_ack & irq_req) != 8'h00) && (((irq_ack - 8'h01) & irq_req) == 8'h00))
    else $error("interrupt priority wrong");
  chk_take_clears_gie: assert property (irq_ack != 8'h00 |=> !gie)
    else $error("gie kept after interrupt entry");
  chk_vector_jump: assert property (irq_ack != 8'h00 |=> pm_addr == $past(ack_vec))
    else $error("fetch not at vector");
  chk_idle_pc_hold: assert property (cpu_idle && $past(cpu_idle) |-> $stable(pm_addr))
    else $error("fetch moved while asleep");
  chk_idle_io_quiet: assert property (cpu_idle |-> !io_wr && !io_rd)
    else $error("i/o strobe while asleep");
  chk_osc_only_asleep: assert property (osc_stop |-> cpu_idle)
    else $error("oscillator stopped while running");
  chk_irq_wakes: assert property (cpu_idle && irq_req != 8'h00 |=> !cpu_idle)
    else $error("no wake on interrupt request");
  chk_status_no_strobe: assert property (io_wr || io_rd |-> io_addr != 6'h3f)
    else $error("strobe for status address");
  cov_irq_taken: cover property (irq_ack != 8'h00);
  cov_power_down: cover property (osc_stop);
  cov_io_write: cover property (io_wr);
  cov_io_read: cover property (io_rd);
endmodule
bind rce_core rce_core_chk i_chk (.mclk(mclk), .rstn(rstn), .pm_addr(pm_addr), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .irq_req(irq_req), .irq_ack(irq_ack), .cpu_idle(cpu_idle), .osc_stop(osc_stop), .gie(gie));

/* File: rce_mem_model.sv */
// Purpose: program memory and i/o peripheral model for the core
// Assumes: program words answer pm_addr in the same cycle
// Notes: keeps a log of the first sixteen i/o writes
`timescale 1ns/1ps
module rce_mem_model (
  input  wire        mclk,
  input  wire        rstn,
  input  wire [8:0]  pm_addr,
  output wire [15:0] pm_data,
  input  wire [5:0]  io_addr,
  input  wire [7:0]  io_wdata,
  input  wire        io_wr,
  input  wire        io_rd,
  output wire [7:0]  io_rdata
);
  logic [15:0] rom   [0:511];
  logic [7:0]  io_q  [0:63];
  logic [5:0]  log_a [0:15];
  logic [7:0]  log_d [0:15];
  int          wr_n;
  assign pm_data = rom[pm_addr];
  // outside a read the bus shows the inverse, so a stale byte never passes
  assign io_rdata = io_rd ? io_q[io_addr] : ~io_q[io_addr];
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int a = 0; a < 64; a++) io_q[a] <= 8'h00;
      wr_n <= 0;
    end else if (io_wr) begin
      io_q[io_addr] <= io_wdata;
      if (wr_n < 16) begin
        log_a[wr_n] <= io_addr;
        log_d[wr_n] <= io_wdata;
      end
      wr_n <= wr_n + 1;
    end
  end
endmodule

/* File: tb_risc_core_execution_control.sv */
// Purpose: self-checking bench of the execution core
// Assumes: 100 MHz mclk, reset held four cycles before each scenario
// Notes: programs use the core's own encoding
`timescale 1ns/1ps
`include "rce_defs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_risc_core_execution_control;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  irq_req = 8'h00;
  logic        sleep_pd = 1'b0;
  logic [7:0]  ack_seen = 8'h00;
  wire  [8:0]  pm_addr;
  wire  [15:0] pm_data;
  wire  [5:0]  io_addr;
  wire  [7:0]  io_wdata;
  wire         io_wr;
  wire         io_rd;
  wire  [7:0]  io_rdata;
  wire  [7:0]  irq_ack;
  wire         cpu_idle;
  wire         osc_stop;
  wire         gie;
  int          num_errors = 0;
  int          comparisons = 0;
  always #5 mclk = ~mclk;
  rce_core i_dut (.mclk(mclk), .rstn(rstn), .pm_addr(pm_addr), .pm_data(pm_data), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .irq_req(irq_req),
    .irq_ack(irq_ack), .sleep_pd(sleep_pd), .cpu_idle(cpu_idle), .osc_stop(osc_stop), .gie(gie));
  rce_mem_model i_mem (.mclk(mclk), .rstn(rstn), .pm_addr(pm_addr), .pm_data(pm_data), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata));
  always @(posedge mclk) begin
    if (!rstn) ack_seen <= 8'h00;
    else if (irq_ack !== 8'h00) ack_seen <= irq_ack;
  end
  task complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task rst_lo;
    @(posedge mclk);
    rstn <= 1'b0;
    for (int a = 0; a < 512; a++) i_mem.rom[a] = 16'hcfff;
  endtask
  task rst_hi;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
  endtask
  task pw(input logic [8:0] a, input logic [15:0] w);
    i_mem.rom[a] = w;
  endtask
  task wait_wr(input int n);
    int k;
    k = 0;
    while (i_mem.wr_n < n && k < 200) begin
      @(posedge mclk);
      k++;
    end
    #1;
  endtask
  task chk_wr(input int i, input logic [5:0] a, input logic [7:0] d);
    `CHK("io addr", a, i_mem.log_a[i])
    `CHK("io data", d, i_mem.log_d[i])
  endtask
  // ldi, add, out, inc, andi, far jump, out
  task t_alu;
    rst_lo;
    pw(9'h000, 16'h7035); pw(9'h001, 16'h710c); pw(9'h002, 16'h0211); pw(9'h003, 16'hba10);
    pw(9'h004, 16'h9210); pw(9'h005, 16'h500f); pw(9'h006, 16'hc1e9); pw(9'h1f0, 16'hba10);
    rst_hi;
    repeat (4) @(posedge mclk);
    #1 `CHK("writes by cycle 4", 0, i_mem.wr_n)
    @(posedge mclk);
    #1 `CHK("writes by cycle 5", 1, i_mem.wr_n)
    wait_wr(2);
    chk_wr(0, 6'h10, 8'h41);
    chk_wr(1, 6'h10, 8'h02);
  endtask
  // pointer store to register and i/o, pointer loads, table byte, sub, skip branch
  task t_ptr;
    rst_lo;
    pw(9'h000, 16'h7e05); pw(9'h001, 16'h7f00); pw(9'h002, 16'h743c); pw(9'h003, 16'h9714);
    pw(9'h004, 16'hb905); pw(9'h005, 16'h7e29); pw(9'h006, 16'h9714); pw(9'h007, 16'h9606);
    pw(9'h008, 16'h9807); pw(9'h009, 16'h08e6); pw(9'h00a, 16'hb947); pw(9'h00b, 16'h20e6);
    pw(9'h00c, 16'ha101); pw(9'h00d, 16'hb967); pw(9'h00e, 16'h7e05); pw(9'h00f, 16'h9609);
    pw(9'h010, 16'hb989); pw(9'h014, 16'he1c3);
    rst_hi;
    wait_wr(4);
    chk_wr(0, 6'h08, 8'h3c);
    chk_wr(1, 6'h09, 8'h3c);
    chk_wr(2, 6'h0a, 8'ha5);
    chk_wr(3, 6'h0c, 8'h3c);
  endtask
  // four nested calls then returns, markers on the way back
  task t_stack;
    rst_lo;
    pw(9'h000, 16'hd009); pw(9'h00a, 16'hd009); pw(9'h014, 16'hd009); pw(9'h01e, 16'hd009);
    pw(9'h00b, 16'hb820); pw(9'h015, 16'hb840); pw(9'h01f, 16'hb860);
    pw(9'h00c, 16'h9900); pw(9'h016, 16'h9900); pw(9'h020, 16'h9900); pw(9'h028, 16'h9900);
    rst_hi;
    wait_wr(4);
    chk_wr(0, 6'h03, 8'h00);
    chk_wr(1, 6'h02, 8'h00);
    chk_wr(2, 6'h01, 8'h00);
    chk_wr(3, 6'h01, 8'h00);
  endtask
  // two sources pending from reset, enable set late by software
  task t_irq;
    rst_lo;
    irq_req <= 8'h06;
    pw(9'h000, 16'hc00f); pw(9'h002, 16'hc01d); pw(9'h003, 16'hc02c);
    pw(9'h010, 16'hb820); pw(9'h011, 16'h9b00); pw(9'h020, 16'hb840); pw(9'h030, 16'hb860);
    rst_hi;
    wait_wr(2);
    chk_wr(0, 6'h01, 8'h00);
    chk_wr(1, 6'h02, 8'h00);
    `CHK("ack", 8'h02, ack_seen)
    `CHK("gie after entry", 1'b0, gie)
    @(posedge mclk);
    irq_req <= 8'h00;
  endtask
  // sleep in power-down then idle, woken by a request with gie clear
  task t_sleep;
    logic pd;
    for (int m = 0; m < 2; m++) begin
      pd = (m == 0);
      rst_lo;
      sleep_pd <= pd;
      pw(9'h000, 16'h705a); pw(9'h001, 16'h9d00); pw(9'h002, 16'hb8f0);
      rst_hi;
      repeat (10) @(posedge mclk);
      #1 `CHK("asleep", 1'b1, cpu_idle)
      `CHK("osc stop", pd, osc_stop)
      `CHK("no io asleep", 0, i_mem.wr_n)
      @(posedge mclk);
      irq_req <= 8'h01;
      wait_wr(1);
      chk_wr(0, 6'h07, 8'h5a);
      `CHK("awake", 1'b0, cpu_idle)
      @(posedge mclk);
      irq_req <= 8'h00;
    end
  endtask
  // out, status write, in, out
  task t_io;
    rst_lo;
    pw(9'h000, 16'h70a5); pw(9'h001, 16'hbfd0); pw(9'h002, 16'hbff0);
    pw(9'h003, 16'hb7d1); pw(9'h004, 16'hb811);
    rst_hi;
    wait_wr(2);
    chk_wr(0, 6'h3e, 8'ha5);
    chk_wr(1, 6'h00, 8'ha5);
    repeat (5) @(posedge mclk);
    #1 `CHK("write count", 2, i_mem.wr_n)
    `CHK("gie from status", 1'b1, gie)
  endtask
  initial begin
    t_alu;
    t_ptr;
    t_stack;
    t_irq;
    t_sleep;
    t_io;
    complete_run;
  end
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
endmodule
